// >>> inc/lsg_pkg.sv
/*
 * Shared constants for the soft-logic LVDS gearbox: counter start values,
 * start-up discard counts and the gearbox mode and state encodings.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package lsg_pkg;
	// Counter power-up values
	localparam int FAST_START        = 0;
	localparam int SLOW_START        = 2;
	// Start-up discard counts common to all configurations
	localparam int RX_RD_DISCARD     = 6;
	localparam int TX_WR_DISCARD     = 2;
	// Receive write discard is three times J fast edges
	localparam int RX_WR_DISCARD_MUL = 3;
	// Slow counter width in every configuration
	localparam int SLOW_CNT_W        = 3;
	// Rate limits, for reference; not used by the logic or the bench
	localparam int BYPASS_MAX_MBPS   = 624;
	localparam int X1_MAX_CLK_MHZ    = 420;
	localparam int X1_DDR_ABOVE_MBPS = 231;
	// Storage option selector
	localparam int OPT_RAM           = 0;
	localparam int OPT_SHIFT         = 1;
	// Start-up tracker states
	typedef enum logic [1:0] {
		LSG_ST_WARM  = 2'b01,
		LSG_ST_VALID = 2'b10
	} lsg_state_type;
endpackage
`default_nettype wire

// >>> rtl/lsg_gearbox.sv
/*
 * Soft-logic LVDS serializer/deserializer used with the hard SERDES bypassed.
 * Core side runs on clock_i (slow word clock); the link side runs on
 * fast_clk_i, which the system must supply at exactly J/2 times clock_i with
 * a fixed phase relation. DDR I/O cells sit outside: this module hands them
 * the rising and falling half bits and the forwarded clock halves.
 */
`timescale 1ns/100ps
`default_nettype none
module lsg_gearbox #(
	parameter int CHANNELS   = 1,   // Channel count
	parameter int J          = 4,   // Bits per channel per word
	parameter int FAST_CNT_W = 4,   // Fast counter width (4/5/5/6)
	parameter int ADDR_W     = 8,   // Physical RAM address width
	parameter int STORE_OPT  = lsg_pkg::OPT_RAM, // RAM or shift register
	parameter bit REG_INPUTS = 1'b1 // Register the parallel transmit word
) (
	// Clocks and reset
	input  wire logic                  clock_i,
	input  wire logic                  fast_clk_i,
	input  wire logic                  rst_b_i,
	// Core transmit and receive words, valid and ready
	input  wire logic [CHANNELS*J-1:0] tx_word_i,
	output logic      [CHANNELS*J-1:0] rx_word_o,
	output logic                       rx_valid_o,
	output logic                       tx_ready_o,
	// Link side DDR halves
	input  wire logic [CHANNELS-1:0]   rx_hi_i,
	input  wire logic [CHANNELS-1:0]   rx_lo_i,
	output logic      [CHANNELS-1:0]   tx_hi_o,
	output logic      [CHANNELS-1:0]   tx_lo_o,
	output logic                       txclk_hi_o,
	output logic                       txclk_lo_o
);
	// Two bits move per fast edge through the DDR halves
	localparam int HALF     = J / 2;
	localparam int DEPTH    = 1 << FAST_CNT_W;
	localparam int WORDS    = 1 << lsg_pkg::SLOW_CNT_W;
	localparam int TX_RD_DISC = J;
	localparam int RX_WR_DISC = lsg_pkg::RX_WR_DISCARD_MUL * J;
	localparam int DW       = 16;

	// Synchronised reset for the fast domain; the core domain uses rst_b_i directly
	logic fast_rst_s1_r, fast_rst_b_r;
	always_ff @(posedge fast_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fast_rst_s1_r <= 1'b0;
			fast_rst_b_r  <= 1'b0;
		end else begin
			fast_rst_s1_r <= 1'b1;
			fast_rst_b_r  <= fast_rst_s1_r;
		end
	end

	// Address counters, wrapping at full width
	logic [FAST_CNT_W-1:0]          fast_cnt_r, fast_cnt_nxt;
	logic [lsg_pkg::SLOW_CNT_W-1:0] slow_cnt_r, slow_cnt_nxt;
	always_comb begin
		fast_cnt_nxt = fast_cnt_r + 1'b1;
		slow_cnt_nxt = slow_cnt_r + 1'b1;
	end
	always_ff @(posedge fast_clk_i or negedge fast_rst_b_r) begin
		if (!fast_rst_b_r)
			fast_cnt_r <= FAST_CNT_W'(lsg_pkg::FAST_START);
		else
			fast_cnt_r <= fast_cnt_nxt;
	end
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i)
			slow_cnt_r <= lsg_pkg::SLOW_CNT_W'(lsg_pkg::SLOW_START);
		else
			slow_cnt_r <= slow_cnt_nxt;
	end

	// Padded physical addresses, upper bits grounded
	logic [ADDR_W-1:0] fast_addr, slow_addr;
	always_comb begin
		fast_addr = '0;
		slow_addr = '0;
		fast_addr[FAST_CNT_W-1:0] = fast_cnt_r;
		slow_addr[lsg_pkg::SLOW_CNT_W-1:0] = slow_cnt_r;
	end

	// Start-up discard counters, 16 bits wide, saturating at their discard counts
	logic [DW-1:0] tx_wr_seen_r, tx_wr_seen_nxt, rx_rd_seen_r, rx_rd_seen_nxt;
	logic [DW-1:0] tx_rd_seen_r, tx_rd_seen_nxt, rx_wr_seen_r, rx_wr_seen_nxt;
	logic          tx_rd_ok_r, tx_rd_ok_nxt; // Read discard over, in step with read data
	lsg_pkg::lsg_state_type rx_st_r, rx_st_nxt;
	always_comb begin
		tx_wr_seen_nxt = tx_wr_seen_r;
		rx_rd_seen_nxt = rx_rd_seen_r;
		if (tx_wr_seen_r < DW'(lsg_pkg::TX_WR_DISCARD))
			tx_wr_seen_nxt = tx_wr_seen_r + 1'b1;
		if (rx_rd_seen_r < DW'(lsg_pkg::RX_RD_DISCARD))
			rx_rd_seen_nxt = rx_rd_seen_r + 1'b1;
	end
	always_comb begin
		tx_rd_seen_nxt = tx_rd_seen_r;
		rx_wr_seen_nxt = rx_wr_seen_r;
		// One cycle late: the RAM read register delays each entry by one edge
		tx_rd_ok_nxt   = (tx_rd_seen_r >= DW'(TX_RD_DISC));
		if (tx_rd_seen_r < DW'(TX_RD_DISC))
			tx_rd_seen_nxt = tx_rd_seen_r + 1'b1;
		if (rx_wr_seen_r < DW'(RX_WR_DISC))
			rx_wr_seen_nxt = rx_wr_seen_r + 1'b1;
	end
	always_ff @(posedge fast_clk_i or negedge fast_rst_b_r) begin
		if (!fast_rst_b_r) begin
			tx_rd_seen_r <= '0;
			rx_wr_seen_r <= '0;
			tx_rd_ok_r   <= 1'b0;
		end else begin
			tx_rd_seen_r <= tx_rd_seen_nxt;
			rx_wr_seen_r <= rx_wr_seen_nxt;
			tx_rd_ok_r   <= tx_rd_ok_nxt;
		end
	end
	// Fast-side write warm-up crosses to the core as a level
	logic rx_wr_ok_f_r, rx_wr_ok_s1_r, rx_wr_ok_s2_r;
	always_ff @(posedge fast_clk_i or negedge fast_rst_b_r) begin
		if (!fast_rst_b_r)
			rx_wr_ok_f_r <= 1'b0;
		else
			rx_wr_ok_f_r <= (rx_wr_seen_r >= DW'(RX_WR_DISC));
	end
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_wr_ok_s1_r <= 1'b0;
			rx_wr_ok_s2_r <= 1'b0;
		end else begin
			rx_wr_ok_s1_r <= rx_wr_ok_f_r;
			rx_wr_ok_s2_r <= rx_wr_ok_s1_r;
		end
	end
	// Receive valid once both write and read warm-up windows have passed
	always_comb begin
		rx_st_nxt = rx_st_r;
		unique case (rx_st_r)
			lsg_pkg::LSG_ST_WARM: begin
				if (rx_wr_ok_s2_r && rx_rd_seen_r >= DW'(lsg_pkg::RX_RD_DISCARD))
					rx_st_nxt = lsg_pkg::LSG_ST_VALID;
			end
			lsg_pkg::LSG_ST_VALID: begin
				rx_st_nxt = lsg_pkg::LSG_ST_VALID;
			end
			default: rx_st_nxt = lsg_pkg::LSG_ST_WARM;
		endcase
	end
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_wr_seen_r <= '0;
			rx_rd_seen_r <= '0;
			rx_st_r      <= lsg_pkg::LSG_ST_WARM;
		end else begin
			tx_wr_seen_r <= tx_wr_seen_nxt;
			rx_rd_seen_r <= rx_rd_seen_nxt;
			rx_st_r      <= rx_st_nxt;
		end
	end

	// Optional input register on the parallel word
	logic [CHANNELS*J-1:0] tx_word_r, tx_word_nxt, tx_word_use;
	always_comb begin
		tx_word_nxt = tx_word_i;
		tx_word_use = REG_INPUTS ? tx_word_r : tx_word_i;
	end
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i)
			tx_word_r <= '0;
		else
			tx_word_r <= tx_word_nxt;
	end

	// Forwarded link clock: DDR halves tied one and zero
	always_ff @(posedge fast_clk_i or negedge fast_rst_b_r) begin
		if (!fast_rst_b_r) begin
			txclk_hi_o <= 1'b0;
			txclk_lo_o <= 1'b0;
		end else begin
			txclk_hi_o <= 1'b1;
			txclk_lo_o <= 1'b0;
		end
	end

	// Load counter, ticks per fast edge; loads the shift register and strobes RAM receive writes
	logic [FAST_CNT_W-1:0] ld_cnt_r, ld_cnt_nxt;
	logic                  ld_en;
	always_comb begin
		ld_en      = (ld_cnt_r == FAST_CNT_W'(HALF - 1));
		ld_cnt_nxt = ld_en ? '0 : ld_cnt_r + 1'b1;
	end
	always_ff @(posedge fast_clk_i or negedge fast_rst_b_r) begin
		if (!fast_rst_b_r)
			ld_cnt_r <= '0;
		else
			ld_cnt_r <= ld_cnt_nxt;
	end

	// Per-channel datapath; channel ch at bits J*(ch+1)-1 downto J*ch
	logic [CHANNELS-1:0] tx_hi_nxt, tx_lo_nxt;
	logic [CHANNELS*J-1:0] rx_word_nxt;
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
			logic [J-1:0] tx_slice;
			assign tx_slice = tx_word_use[J*(ch+1)-1 -: J];
			if (STORE_OPT == lsg_pkg::OPT_RAM) begin : g_ram
				// Simple dual-port RAMs; receive write enabled by ld_en, other enables always high
				logic [1:0] tx_mem [DEPTH];
				logic [J-1:0] rx_mem [WORDS];
				logic [1:0] tx_rd_r;
				logic [J-1:0] rx_rd_r;
				logic [J-1:0] rx_acc_r, rx_acc_nxt;
				// Transmit write: slow address, one word per slow edge
				always_ff @(posedge clock_i) begin
					for (int b = 0; b < HALF; b++)
						tx_mem[(32'(slow_addr[lsg_pkg::SLOW_CNT_W-1:0]) * HALF + b)
							% DEPTH] <= tx_slice[J-1-2*b -: 2];
				end
				// Transmit read: fast address, one pair per fast edge
				always_ff @(posedge fast_clk_i) begin
					tx_rd_r <= tx_mem[fast_addr[FAST_CNT_W-1:0]];
				end
				// Receive write: fast address collects pairs into a word
				always_comb begin
					rx_acc_nxt = {rx_acc_r[J-3:0], rx_hi_i[ch], rx_lo_i[ch]};
				end
				always_ff @(posedge fast_clk_i) begin
					rx_acc_r <= rx_acc_nxt;
					if (ld_en)
						rx_mem[fast_addr[FAST_CNT_W-1:0] / HALF % WORDS] <= rx_acc_nxt;
				end
				// Receive read: slow address, one word per slow edge
				always_ff @(posedge clock_i) begin
					rx_rd_r <= rx_mem[slow_addr[lsg_pkg::SLOW_CNT_W-1:0]];
				end
				always_comb begin
					tx_hi_nxt[ch] = tx_rd_ok_r && tx_rd_r[1];
					tx_lo_nxt[ch] = tx_rd_ok_r && tx_rd_r[0];
					rx_word_nxt[J*(ch+1)-1 -: J] = rx_rd_r;
				end
			end else begin : g_shift
				// Shift register with load enable from the counter
				logic [J-1:0] sh_r, sh_nxt, rsh_r, rsh_nxt, cap_r;
				always_comb begin
					sh_nxt  = ld_en ? tx_slice : {sh_r[J-3:0], 2'b00};
					rsh_nxt = {rsh_r[J-3:0], rx_hi_i[ch], rx_lo_i[ch]};
				end
				always_ff @(posedge fast_clk_i) begin
					sh_r  <= sh_nxt;
					rsh_r <= rsh_nxt;
				end
				// Extra slow-clock capture of the deserialised word
				always_ff @(posedge clock_i) begin
					cap_r <= rsh_r;
				end
				always_comb begin
					tx_hi_nxt[ch] = sh_r[J-1];
					tx_lo_nxt[ch] = sh_r[J-2];
					rx_word_nxt[J*(ch+1)-1 -: J] = cap_r;
				end
			end
		end
	endgenerate

	// Link outputs registered on the fast clock for the DDR cells
	always_ff @(posedge fast_clk_i or negedge fast_rst_b_r) begin
		if (!fast_rst_b_r) begin
			tx_hi_o <= '0;
			tx_lo_o <= '0;
		end else begin
			tx_hi_o <= tx_hi_nxt;
			tx_lo_o <= tx_lo_nxt;
		end
	end
	// Core outputs; word held zero until the start-up window ends
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_word_o  <= '0;
			rx_valid_o <= 1'b0;
			tx_ready_o <= 1'b0;
		end else begin
			rx_valid_o <= (rx_st_r == lsg_pkg::LSG_ST_VALID);
			rx_word_o  <= (rx_st_r == lsg_pkg::LSG_ST_VALID) ? rx_word_nxt : '0;
			tx_ready_o <= (tx_wr_seen_r >= DW'(lsg_pkg::TX_WR_DISCARD));
		end
	end
	// Rate limits are system-level and not checked in logic
endmodule
`default_nettype wire

// >>> test/lsg_gearbox_assertions.sv
/* Port checker for the LVDS gearbox.
   Assumes the fast clock is aligned to clock_i and shares rst_b_i. */
`timescale 1ns/100ps
`default_nettype none
module lsg_gearbox_assertions #(
	parameter int CHANNELS = 1, // Channel count
	parameter int J        = 4  // Bits per channel word
) (
	// Clocks and reset
	input wire logic                  clock_i,
	input wire logic                  fast_clk_i,
	input wire logic                  rst_b_i,
	// Core side
	input wire logic [CHANNELS*J-1:0] tx_word_i,
	input wire logic [CHANNELS*J-1:0] rx_word_o,
	input wire logic                  rx_valid_o,
	input wire logic                  tx_ready_o,
	// Link side
	input wire logic [CHANNELS-1:0]   rx_hi_i,
	input wire logic [CHANNELS-1:0]   rx_lo_i,
	input wire logic [CHANNELS-1:0]   tx_hi_o,
	input wire logic [CHANNELS-1:0]   tx_lo_o,
	input wire logic                  txclk_hi_o,
	input wire logic                  txclk_lo_o
);
	logic [3:0] scnt_r, scnt_nxt; // Slow edges since reset
	logic [3:0] fcnt_r, fcnt_nxt; // Fast edges since reset
	// Saturate so a long run never wraps back into warm-up
	always_comb begin
		scnt_nxt = (scnt_r == 4'hF) ? scnt_r : scnt_r + 4'h1;
		fcnt_nxt = (fcnt_r == 4'hF) ? fcnt_r : fcnt_r + 4'h1;
	end
	// Slow edge counter
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) scnt_r <= 4'h0;
		else scnt_r <= scnt_nxt;
	end
	// Fast edge counter
	always_ff @(posedge fast_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) fcnt_r <= 4'h0;
		else fcnt_r <= fcnt_nxt;
	end
	// Ready, once up, holds for two edges
	sequence s_ready_on;
		tx_ready_o ##1 tx_ready_o;
	endsequence
	a_ready_early: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(scnt_r < 4'h2) |-> !tx_ready_o) else $error("ready during write discard");
	a_ready_late: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(scnt_r == 4'h8) |-> tx_ready_o) else $error("ready missing after discard");
	a_ready_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		tx_ready_o |-> s_ready_on) else $error("ready dropped");
	a_rx_discard: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(scnt_r < 4'h6) |-> !rx_valid_o) else $error("valid during read discard");
	a_rx_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!rx_valid_o |-> (rx_word_o == '0)) else $error("word not zero while invalid");
	a_valid_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		rx_valid_o |=> rx_valid_o) else $error("valid dropped");
	a_tx_discard: assert property (@(posedge fast_clk_i) disable iff (!rst_b_i)
		(fcnt_r < 4'h4) |-> (tx_hi_o == '0 && tx_lo_o == '0)) else $error("tx bits in discard");
	a_clk_fwd: assert property (@(posedge fast_clk_i) disable iff (!rst_b_i)
		(fcnt_r > 4'h5) |-> (txclk_hi_o && !txclk_lo_o)) else $error("clock halves wrong");
endmodule
bind lsg_gearbox lsg_gearbox_assertions #(.CHANNELS(CHANNELS), .J(J)) u_chk (
	.clock_i(clock_i), .fast_clk_i(fast_clk_i), .rst_b_i(rst_b_i), .tx_word_i(tx_word_i),
	.rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o), .tx_ready_o(tx_ready_o),
	.rx_hi_i(rx_hi_i), .rx_lo_i(rx_lo_i), .tx_hi_o(tx_hi_o), .tx_lo_o(tx_lo_o),
	.txclk_hi_o(txclk_hi_o), .txclk_lo_o(txclk_lo_o));
`default_nettype wire

// >>> test/lsg_link_partner.sv
/* Far LVDS device: echoes the serial stream back as its own transmit.
   Assumes it sits on the DDR halves and shares the fast clock. */
`timescale 1ns/100ps
`default_nettype none
module lsg_link_partner #(
	parameter int CHANNELS = 1 // Channel count
) (
	// Link clock and reset
	input  wire logic                fast_clk_i,
	input  wire logic                rst_b_i,
	// Halves from and to the gearbox
	input  wire logic [CHANNELS-1:0] tx_hi_i,
	input  wire logic [CHANNELS-1:0] tx_lo_i,
	output logic      [CHANNELS-1:0] rx_hi_o,
	output logic      [CHANNELS-1:0] rx_lo_o
);
	// Echo keeps hi as the earlier bit, one fast cycle late
	always_ff @(posedge fast_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_hi_o <= '1; // Idle pattern differs from echoed data
			rx_lo_o <= '0;
		end else begin
			rx_hi_o <= tx_hi_i;
			rx_lo_o <= tx_lo_i;
		end
	end
endmodule
`default_nettype wire

// >>> test/lsg_gearbox_tb.sv
/* Self-checking bench for the gearbox with an echoing far device.
   Assumes the fast clock is twice clock_i for J of 4, 1 ns behind it.
   A second gearbox runs the shift option with unregistered inputs. */
`timescale 1ns/100ps
`default_nettype none
module lsg_gearbox_tb;
	logic       clock_i = 1'b0;    // Core clock, 8 ns
	logic       fast_clk_i = 1'b1; // Link clock, phase-related, 1 ns late
	logic       rst_b_i = 1'b0;    // Reset, active low
	logic [3:0] tx_word_i = 4'h0;  // Transmit word
	logic [3:0] rx_word_o;         // Received word
	logic       rx_valid_o, tx_ready_o, txclk_hi_o, txclk_lo_o;
	logic       rx_hi_i, rx_lo_i, tx_hi_o, tx_lo_o;
	logic [3:0] sh_rx_word_o;      // Shift option: received word
	logic       sh_rx_valid_o, sh_tx_ready_o, sh_txclk_hi_o, sh_txclk_lo_o;
	logic       sh_rx_hi_i, sh_rx_lo_i, sh_tx_hi_o, sh_tx_lo_o;
	int         num_errors = 0;    // Mismatches
	int         total_checks = 0;  // Comparisons
	// Ratio fixed by the gearbox, not by the nominal link rate
	initial forever #4 clock_i = ~clock_i;
	// Offset keeps reset release and stimulus off the fast edges
	initial begin
		#1;
		forever #2 fast_clk_i = ~fast_clk_i;
	end
	lsg_gearbox #(.CHANNELS(1), .J(4), .FAST_CNT_W(4), .ADDR_W(8)) u_dut (
		.clock_i(clock_i), .fast_clk_i(fast_clk_i), .rst_b_i(rst_b_i),
		.tx_word_i(tx_word_i), .rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o),
		.tx_ready_o(tx_ready_o), .rx_hi_i(rx_hi_i), .rx_lo_i(rx_lo_i), .tx_hi_o(tx_hi_o),
		.tx_lo_o(tx_lo_o), .txclk_hi_o(txclk_hi_o), .txclk_lo_o(txclk_lo_o));
	lsg_link_partner #(.CHANNELS(1)) u_far (.fast_clk_i(fast_clk_i), .rst_b_i(rst_b_i),
		.tx_hi_i(tx_hi_o), .tx_lo_i(tx_lo_o), .rx_hi_o(rx_hi_i), .rx_lo_o(rx_lo_i));
	// Shift-register option, parallel word used straight from the port
	lsg_gearbox #(.CHANNELS(1), .J(4), .FAST_CNT_W(4), .ADDR_W(8),
		.STORE_OPT(lsg_pkg::OPT_SHIFT), .REG_INPUTS(1'b0)) u_dut_sh (
		.clock_i(clock_i), .fast_clk_i(fast_clk_i), .rst_b_i(rst_b_i),
		.tx_word_i(tx_word_i), .rx_word_o(sh_rx_word_o), .rx_valid_o(sh_rx_valid_o),
		.tx_ready_o(sh_tx_ready_o), .rx_hi_i(sh_rx_hi_i), .rx_lo_i(sh_rx_lo_i),
		.tx_hi_o(sh_tx_hi_o), .tx_lo_o(sh_tx_lo_o), .txclk_hi_o(sh_txclk_hi_o),
		.txclk_lo_o(sh_txclk_lo_o));
	lsg_link_partner #(.CHANNELS(1)) u_far_sh (.fast_clk_i(fast_clk_i), .rst_b_i(rst_b_i),
		.tx_hi_i(sh_tx_hi_o), .tx_lo_i(sh_tx_lo_o), .rx_hi_o(sh_rx_hi_i),
		.rx_lo_o(sh_rx_lo_i));
	// Compare and count
	task automatic check(string what, logic [3:0] exp, logic [3:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask
	// Verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Reset for six cycles, then look at the start-up outputs
	task automatic t_reset();
		@(negedge clock_i) rst_b_i = 1'b0;
		repeat (6) @(negedge clock_i);
		check("reset outputs", 4'h0, {tx_ready_o, rx_valid_o, tx_hi_o, txclk_hi_o});
		check("shift reset outputs", 4'h0, {sh_tx_ready_o, sh_rx_valid_o, sh_tx_hi_o, sh_txclk_hi_o});
		rst_b_i = 1'b1;
		@(negedge clock_i);
		check("ready early", 4'h0, {2'h0, sh_tx_ready_o, tx_ready_o});
		repeat (8) @(negedge clock_i);
		check("ready late", 4'h3, {2'h0, sh_tx_ready_o, tx_ready_o});
		check("clock halves", 4'hA, {sh_txclk_hi_o, sh_txclk_lo_o, txclk_hi_o, txclk_lo_o});
	endtask
	// Serial halves: pairs MSB first, hi is the earlier bit
	task automatic t_tx_pairs(logic [3:0] w);
		logic [1:0] s [8];
		logic [1:0] q [8];
		logic       ph, qph;
		@(negedge clock_i) tx_word_i = w;
		repeat (30) @(negedge clock_i);
		// Pairs from both options, sampled mid fast cycle
		for (int k = 0; k < 8; k++) begin
			@(negedge fast_clk_i);
			s[k] = {tx_hi_o, tx_lo_o};
			q[k] = {sh_tx_hi_o, sh_tx_lo_o};
		end
		ph  = (s[0] === w[1:0] && w[3:2] !== w[1:0]);
		qph = (q[0] === w[1:0] && w[3:2] !== w[1:0]);
		for (int k = 0; k < 8; k++) begin
			check("tx pair", {2'h0, ((k % 2 == 0) ^ ph) ? w[3:2] : w[1:0]}, {2'h0, s[k]});
			check("shift tx pair", {2'h0, ((k % 2 == 0) ^ qph) ? w[3:2] : w[1:0]}, {2'h0, q[k]});
		end
	endtask
	// Echoed stream comes back as the same word
	task automatic t_loopback(logic [3:0] w);
		int n;
		@(negedge clock_i) tx_word_i = w;
		t_reset();
		n = 0;
		while (rx_valid_o !== 1'b1 && n < 100) begin
			@(negedge clock_i) n++;
		end
		check("rx valid", 4'h3, {2'h0, sh_rx_valid_o, rx_valid_o});
		repeat (20) @(negedge clock_i);
		check("rx word", w, rx_word_o);
		check("shift rx word", w, sh_rx_word_o);
	endtask
	// Watchdog
	initial begin
		#200000;
		num_errors++;
		report_and_stop();
	end
	// Main sequence, a further reset in mid-run inside each loopback
	initial begin
		t_reset();
		t_tx_pairs(4'hA);
		t_tx_pairs(4'h5);
		t_tx_pairs(4'hC);
		t_tx_pairs(4'h6);
		t_loopback(4'h5);
		t_loopback(4'hA);
		report_and_stop();
	end
endmodule
`default_nettype wire
